// ---- dscp_serial_port.sv ----
module dscp_serial_port (
	// System clock and reset
	input  wire logic CLK,
	input  wire logic RESETN,
	// Hardware reset pin, active high, asynchronous to CLK
	input  wire logic HW_RESET,
	// Serial link
	input  wire logic SERIAL_CLK,
	input  wire logic SERIAL_CHIP_SELECT_N,
	input  wire logic SDIO_I,
	output logic      SDIO_O,
	output logic      SDIO_OE,
	output logic      AUX_SERIAL_OUT,
	output logic      AUX_SERIAL_OUT_OE,
	// Data rate clock to mirror onto the aux pin
	input  wire logic DATA_RATE_CLK,
	// Register image on the system clock
	output logic [dscp_pkg::DSCP_NUM_REGS*dscp_pkg::DSCP_DATA_BITS-1:0] REG_IMAGE
);
	import dscp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Link domain reset: chip select high or hardware reset clears the port
	logic port_rst_n;
	assign port_rst_n = ~SERIAL_CHIP_SELECT_N & ~HW_RESET & RESETN;

	// Register bank reset: hardware reset pin or RESETN, never chip select
	logic bank_rst_n;
	assign bank_rst_n = ~HW_RESET & RESETN;

	typedef struct packed {
		dscp_state_t                  st;
		logic [4:0]                   cnt;
		logic                         rd;
		logic [DSCP_ADDR_BITS-1:0]    addr;
		logic [DSCP_DATA_BITS-1:0]    shift;
	} dscp_link_t;

	typedef struct packed {
		logic [DSCP_NUM_REGS-1:0][DSCP_DATA_BITS-1:0] regs;
		logic                                        wr_tgl;
	} dscp_bank_t;

	dscp_link_t lk;
	dscp_link_t next_lk;
	dscp_bank_t bk;
	dscp_bank_t next_bk;

	// Write commit computed combinationally from the last rising edge
	logic                      wr_fire;
	logic [DSCP_ADDR_BITS-1:0] wr_addr;
	logic [DSCP_DATA_BITS-1:0] wr_data;

	// Serial shifter step, MSB first
	function automatic logic [DSCP_DATA_BITS-1:0] shift_in(
		input logic [DSCP_DATA_BITS-1:0] cur,
		input logic                      bit_in
	);
		return {cur[DSCP_DATA_BITS-2:0], bit_in};
	endfunction : shift_in

	// Bit counter step; the done state holds, so it never wraps
	function automatic logic [4:0] cnt_step(input logic [4:0] cur);
		return cur + 5'h01;
	endfunction : cnt_step

	////////////////////////////////////////////////////////////////////////////
	// Bit counter and shifter on the rising serial edge
	always_comb begin
		next_lk  = lk;
		wr_fire  = 1'b0;
		wr_addr  = lk.addr;
		wr_data  = shift_in(lk.shift, SDIO_I);
		case (lk.st)
			DSCP_ST_INSTR: begin
				next_lk.shift = shift_in(lk.shift, SDIO_I);
				next_lk.cnt   = cnt_step(lk.cnt);
				if (lk.cnt == DSCP_CNT_INSTR) begin
					next_lk.rd   = lk.shift[DSCP_RW_BIT-1];
					next_lk.addr = {lk.shift[DSCP_ADDR_BITS-2:0], SDIO_I};
					next_lk.st   = lk.shift[DSCP_RW_BIT-1] ? DSCP_ST_READ : DSCP_ST_WRITE;
				end
			end
			DSCP_ST_WRITE: begin
				next_lk.shift = shift_in(lk.shift, SDIO_I);
				next_lk.cnt   = cnt_step(lk.cnt);
				if (lk.cnt == DSCP_CNT_LAST) begin
					wr_fire    = 1'b1;
					next_lk.st = DSCP_ST_DONE;
				end
			end
			DSCP_ST_READ: begin
				next_lk.cnt = cnt_step(lk.cnt);
				if (lk.cnt == DSCP_CNT_LAST) begin
					next_lk.st = DSCP_ST_DONE;
				end
			end
			default: begin
				next_lk.st = DSCP_ST_DONE; // Wait for chip select to rise
			end
		endcase
	end

	always_ff @(posedge SERIAL_CLK or negedge port_rst_n) begin
		if (!port_rst_n) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bank on the serial clock, so writes need no running CLK.
	// Soft reset spares address zero by design.
	always_comb begin
		next_bk = bk;
		if (wr_fire) begin
			if (wr_addr == DSCP_CFG_ADDR && wr_data[DSCP_CFG_SWR_BIT]) begin
				for (int i = 1; i < DSCP_NUM_REGS; i++) begin
					next_bk.regs[i] = DSCP_REG_RESET;
				end
				next_bk.regs[0] = bk.regs[0];
			end else begin
				next_bk.regs[wr_addr] = wr_data;
			end
			next_bk.wr_tgl = ~bk.wr_tgl;
		end
	end

	always_ff @(posedge SERIAL_CLK or negedge bank_rst_n) begin
		if (!bank_rst_n) begin
			bk <= '0;
		end else begin
			bk <= next_bk;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data bit selected by position within the data phase
	logic [DSCP_DATA_BITS-1:0] rd_word;
	logic [2:0]                rd_idx;
	assign rd_word = bk.regs[lk.addr];
	assign rd_idx  = 3'(DSCP_CNT_LAST - lk.cnt);

	// Rate clock crosses into the serial clock domain through two flops.
	// Limitation: it only advances while the host clocks a frame, so the
	// aux pin shows the rate clock during frames only.
	logic [1:0] rate_sync;
	always_ff @(negedge SERIAL_CLK or negedge port_rst_n) begin
		if (!port_rst_n) begin
			rate_sync <= 2'b00;
		end else begin
			rate_sync <= {rate_sync[0], DATA_RATE_CLK};
		end
	end

	dscp_cfg_if cfg ();
	assign cfg.sdio_out_en  = bk.regs[0][DSCP_CFG_DIR_BIT];
	assign cfg.aux_rate_clk = bk.regs[0][DSCP_CFG_AUX_BIT];
	assign cfg.rd_bit       = rd_word[rd_idx];
	assign cfg.rd_active    = (lk.st == DSCP_ST_READ);

	logic clk_n;
	assign clk_n = ~SERIAL_CLK; // Falling edge launch

	dscp_pin_drv u_pin_drv (
		.clk_n    (clk_n),
		.rst_n    (port_rst_n),
		.cfg      (cfg),
		.rate_clk (rate_sync[1]),
		.sdio_o   (SDIO_O),
		.sdio_oe  (SDIO_OE),
		.aux_o    (AUX_SERIAL_OUT),
		.aux_oe   (AUX_SERIAL_OUT_OE)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register image into CLK: toggle handshake, data stable once toggle seen.
	// Hardware reset clears the bank without a toggle, so it is synced here
	// on its own and clears the image directly.
	typedef struct packed {
		logic [1:0]                                   hw;
		logic [2:0]                                   tgl;
		logic [DSCP_NUM_REGS*DSCP_DATA_BITS-1:0]      img;
	} dscp_sys_t;

	dscp_sys_t sy;
	dscp_sys_t next_sy;

	always_comb begin
		next_sy     = sy;
		next_sy.hw  = {sy.hw[0], HW_RESET};
		next_sy.tgl = {sy.tgl[1:0], bk.wr_tgl};
		if (sy.hw[1]) begin
			next_sy.img = {DSCP_NUM_REGS{DSCP_REG_RESET}};
		end else if (sy.tgl[2] != sy.tgl[1]) begin
			next_sy.img = bk.regs; // Bank is quiet after a write until next frame
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sy <= '0;
		end else begin
			sy <= next_sy;
		end
	end

	assign REG_IMAGE = sy.img;
endmodule : dscp_serial_port

// ---- dscp_pkg.sv ----
package dscp_pkg;
	// Serial framing
	localparam int          DSCP_INSTR_BITS  = 8;
	localparam int          DSCP_DATA_BITS   = 8;
	localparam int          DSCP_ADDR_BITS   = 5;
	localparam int          DSCP_NUM_REGS    = 32;
	localparam int          DSCP_RW_BIT      = 7;
	// Configuration register at address zero
	localparam logic [4:0]  DSCP_CFG_ADDR    = 5'h00;
	localparam int          DSCP_CFG_DIR_BIT = 7;
	localparam int          DSCP_CFG_SWR_BIT = 5;
	localparam int          DSCP_CFG_AUX_BIT = 4;
	localparam logic [7:0]  DSCP_REG_RESET   = 8'h00;
	localparam logic [7:0]  DSCP_CFG_WMASK   = 8'h00;
	// Bit counter value at the last frame bit and at the last instruction bit
	localparam logic [4:0]  DSCP_CNT_LAST    = 5'h0F;
	localparam logic [4:0]  DSCP_CNT_INSTR   = 5'h07;

	// Link side state
	typedef enum logic [1:0] {
		DSCP_ST_INSTR = 2'b00,
		DSCP_ST_WRITE = 2'b01,
		DSCP_ST_READ  = 2'b10,
		DSCP_ST_DONE  = 2'b11
	} dscp_state_t;
endpackage : dscp_pkg

// ---- dscp_cfg_if.sv ----
// Config bits handed from the register bank to the pin driver
interface dscp_cfg_if;
	logic sdio_out_en;
	logic aux_rate_clk;
	logic rd_bit;
	logic rd_active;
	modport bank (output sdio_out_en, output aux_rate_clk, output rd_bit, output rd_active);
	modport pins (input sdio_out_en, input aux_rate_clk, input rd_bit, input rd_active);
endinterface : dscp_cfg_if

// ---- dscp_pin_drv.sv ----
// Falling edge launch of read data onto the two data pins
module dscp_pin_drv (
	// Link clock and reset
	input  wire logic clk_n,
	input  wire logic rst_n,
	// Configuration from the register bank
	dscp_cfg_if.pins  cfg,
	// Rate clock already on the link domain
	input  wire logic rate_clk,
	// Pin side
	output logic      sdio_o,
	output logic      sdio_oe,
	output logic      aux_o,
	output logic      aux_oe
);
	import dscp_pkg::*;

	typedef struct packed {
		logic sdio_o;
		logic sdio_oe;
		logic aux_o;
		logic aux_oe;
	} dscp_drv_t;

	dscp_drv_t s;
	dscp_drv_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// Direction bit picks which pin carries read data
	always_comb begin
		next_s         = s;
		next_s.sdio_oe = cfg.sdio_out_en & cfg.rd_active;
		next_s.sdio_o  = cfg.rd_bit;
		next_s.aux_oe  = ~cfg.sdio_out_en;
		next_s.aux_o   = cfg.aux_rate_clk ? rate_clk : cfg.rd_bit;
	end

	// Registered on the falling serial edge, cleared by chip select high
	always_ff @(posedge clk_n or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sdio_o  = s.sdio_o;
	assign sdio_oe = s.sdio_oe;
	assign aux_o   = s.aux_o;
	assign aux_oe  = s.aux_oe;
endmodule : dscp_pin_drv

// ---- dscp_serial_port_monitor.sv ----
module dscp_serial_port_monitor (
	// Clocks and resets
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic HW_RESET,
	// Serial link
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_CHIP_SELECT_N,
	input wire logic SDIO_O,
	input wire logic SDIO_OE,
	input wire logic AUX_SERIAL_OUT,
	input wire logic AUX_SERIAL_OUT_OE,
	input wire logic DATA_RATE_CLK,
	// Register image
	input wire logic [dscp_pkg::DSCP_NUM_REGS*dscp_pkg::DSCP_DATA_BITS-1:0] REG_IMAGE
);
	////////////////////////////////
	// Falls seen in the current frame, saturating; chip select high clears it
	logic [2:0] falls;
	always_ff @(negedge SERIAL_CLK or posedge SERIAL_CHIP_SELECT_N) begin
		if (SERIAL_CHIP_SELECT_N) begin
			falls <= 3'h0;
		end else if (falls != 3'h7) begin
			falls <= falls + 3'h1;
		end
	end

	////////////////////////////////
	// Image lags the link, so each check leans on it one way only
	AST_OE_NEEDS_DIR: assert property (@(posedge CLK) disable iff (!RESETN)
		SDIO_OE |-> REG_IMAGE[7]) else $error("pin driven, dir clear");
	AST_OE_HW_OFF: assert property (@(posedge CLK) disable iff (!RESETN)
		HW_RESET |-> ##[0:1] !SDIO_OE) else $error("pin driven in reset");
	AST_AUX_YIELDS: assert property (@(negedge SERIAL_CLK) disable iff (!RESETN || HW_RESET)
		SDIO_OE |-> !AUX_SERIAL_OUT_OE) else $error("both outputs on");
	AST_CS_DROPS_OE: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(SERIAL_CHIP_SELECT_N) |-> ##[0:2] !SDIO_OE) else $error("oe held past cs");
	AST_HW_CLEARS: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(HW_RESET) |-> ##[1:8] REG_IMAGE == '0) else $error("regs kept");
	AST_SOFT_KEEPS_CFG: assert property (@(posedge CLK) disable iff (!RESETN || HW_RESET)
		$changed(REG_IMAGE[255:8]) |-> $stable(REG_IMAGE[7:0])) else $error("cfg moved");
	AST_LAUNCH_FALL: assert property (@(posedge CLK) disable iff (!RESETN || HW_RESET)
		$changed(SDIO_O) |-> !SERIAL_CLK || SERIAL_CHIP_SELECT_N) else $error("launch on rise");
	AST_AUX_RATE: assert property (@(negedge SERIAL_CLK) disable iff (!RESETN || HW_RESET)
		!SERIAL_CHIP_SELECT_N && falls >= 3'h3 && REG_IMAGE[4] && $past(REG_IMAGE[4])
		|-> AUX_SERIAL_OUT == $past(DATA_RATE_CLK, 3)) else $error("aux not rate clock");
	COV_PIN_READ: cover property (@(posedge CLK) SDIO_OE);
	COV_HW: cover property (@(posedge CLK) $rose(HW_RESET));
	COV_RATE: cover property (@(posedge CLK) REG_IMAGE[4]);
endmodule : dscp_serial_port_monitor

bind dscp_serial_port dscp_serial_port_monitor mon (.CLK, .RESETN, .HW_RESET, .SERIAL_CLK,
	.SERIAL_CHIP_SELECT_N, .SDIO_O, .SDIO_OE, .AUX_SERIAL_OUT, .AUX_SERIAL_OUT_OE,
	.DATA_RATE_CLK, .REG_IMAGE);

// ---- dscp_host_model.sv ----
module dscp_host_model #(
	parameter int HALF = 6
) (
	// Link outputs
	output logic      sclk,
	output logic      csn,
	output logic      sdio_i,
	// Device outputs
	input wire logic  sdio_o,
	input wire logic  sdio_oe,
	input wire logic  aux_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic drv;
	// Device wins the shared wire while it drives
	assign sdio_i = sdio_oe ? sdio_o : drv;
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		drv = 1'b0;
	end
	////////////////////////////////
	// n bits MSB first; clock stands still between frames
	task automatic frame(input logic [15:0] w, input int n, output logic [7:0] qp, qa);
		#0.3 csn = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			drv = (w[15] && i < 8) ? ~drv : w[i]; // Released line toggles, no stale bit
			#HALF sclk = 1'b1;
			if (i < 8) begin
				qp[i] = sdio_i;
				qa[i] = aux_o;
			end
			#HALF sclk = 1'b0;
		end
		#HALF csn = 1'b1;
		#(5 * HALF);
	endtask : frame
endmodule : dscp_host_model

// ---- dscp_serial_port_tb.sv ----
module dscp_serial_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK, RESETN, HW_RESET, DATA_RATE_CLK, SERIAL_CLK, SERIAL_CHIP_SELECT_N, SDIO_I;
	logic SDIO_O, SDIO_OE, AUX_SERIAL_OUT, AUX_SERIAL_OUT_OE;
	logic [255:0] REG_IMAGE;
	logic [7:0]   p, q;
	int           miscompares, tests_run, cyc;
	logic         aux_oe_seen;
	// Aux enable as last seen inside a frame; drivers clear once chip select rises
	always @(posedge SERIAL_CLK) begin
		if (!SERIAL_CHIP_SELECT_N) begin
			aux_oe_seen <= AUX_SERIAL_OUT_OE;
		end
	end
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	// Slow rate clock so a frame sees at most one edge of it
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		DATA_RATE_CLK <= cyc[6];
	end
	dscp_serial_port dut (.CLK, .RESETN, .HW_RESET, .SERIAL_CLK, .SERIAL_CHIP_SELECT_N, .SDIO_I,
		.SDIO_O, .SDIO_OE, .AUX_SERIAL_OUT, .AUX_SERIAL_OUT_OE, .DATA_RATE_CLK, .REG_IMAGE);
	dscp_host_model host (.sclk(SERIAL_CLK), .csn(SERIAL_CHIP_SELECT_N), .sdio_i(SDIO_I),
		.sdio_o(SDIO_O), .sdio_oe(SDIO_OE), .aux_o(AUX_SERIAL_OUT));
	////////////////////////////////
	task automatic chk(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] x, y;
		host.frame({3'b000, a, d}, 16, x, y);
	endtask : wr
	task automatic rd(input logic [4:0] a);
		host.frame({3'b100, a, 8'h00}, 16, p, q);
	endtask : rd
	////////////////////////////////
	task automatic t_reset;
		rd(5'h00);
		chk(q, 8'h00);
		chk({7'h0, aux_oe_seen}, 8'h01);
		chk({7'h0, AUX_SERIAL_OUT_OE}, 8'h00);
		$display("reset done");
	endtask : t_reset
	task automatic t_wrrd;
		wr(5'h05, 8'hA5);
		wr(5'h06, 8'h3C);
		rd(5'h05);
		chk(q, 8'hA5);
		host.frame({3'b000, 5'h05, 8'hFF}, 5, p, q);
		rd(5'h05);
		chk(q, 8'hA5);
		repeat (10) @(posedge CLK);
		chk(REG_IMAGE[55:48], 8'h3C);
		$display("write read done");
	endtask : t_wrrd
	task automatic t_dir_soft;
		wr(5'h00, 8'h80);
		rd(5'h06);
		chk(p, 8'h3C);
		chk({7'h0, aux_oe_seen}, 8'h00);
		wr(5'h00, 8'h20);
		rd(5'h06);
		chk(p, 8'h00);
		rd(5'h00);
		chk(p, 8'h80);
		$display("direction and soft reset done");
	endtask : t_dir_soft
	task automatic t_rate_hw;
		wr(5'h00, 8'h10);
		wr(5'h09, 8'h5A);
		rd(5'h06);
		chk(REG_IMAGE[7:0], 8'h10);
		chk({7'h0, aux_oe_seen}, 8'h01);
		@(posedge CLK);
		HW_RESET <= 1'b1;
		repeat (20) @(posedge CLK);
		HW_RESET <= 1'b0;
		repeat (4) @(posedge CLK);
		chk(REG_IMAGE[79:72], 8'h00);
		chk(REG_IMAGE[7:0], 8'h00);
		$display("rate and hardware reset done");
	endtask : t_rate_hw
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		RESETN = 1'b0;
		HW_RESET = 1'b0;
		repeat (12) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (4) @(posedge CLK);
		t_reset();
		t_wrrd();
		t_dir_soft();
		t_rate_hw();
		give_verdict();
	end
	// Hang guard
	initial begin
		#50000;
		miscompares++;
		give_verdict();
	end
endmodule : dscp_serial_port_tb
